/* hdl/tae_sequencer.sv */
// card-side t0 command and response sequencer with card operating state
`include "tae_params.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// R1: header with length 00 and no data ends with status 90 00.
// R2: length 00 on a data fetch gets 6C plus true length; reissue returns data.
// R3: outgoing data follows the echoed instruction byte; card then answers 90 00.
// R4: after command data, 61 plus count; GET RESPONSE returns C0, data, status.
// R5: fetch reply may end 61 plus count again until data runs out with 90 00.
// R6: terminal may ask with length 00 meaning 256 bytes.
// R7: pending warning 62 replaces 90 00 at the end of the fetched response.
// R8: inactive state while powered off; nothing is processed there.
// R9: application management entered when powered; left once all PINs verified.
// R10: operation state only after at least one session activated successfully.
// R11: terminal waits for a procedure byte before data or the next command.
module tae_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// card power and application status from the card core
	input  wire logic        power_on,
	input  wire logic        pins_verified,
	input  wire logic        session_ok,
	// bytes from the terminal, already framed
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	// bytes to the terminal, one pulse per byte, framer accepts every byte
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	// decoded command to the application logic
	output logic      [7:0]  cmd_ins,
	output logic             cmd_start,
	output logic      [7:0]  cmd_byte,
	output logic             cmd_byte_valid,
	// application answer: response length, warning qualifier, done pulse
	input  wire logic        app_done,
	input  wire logic [15:0] app_resp_len,
	input  wire logic        app_warn,
	input  wire logic [7:0]  app_warn_qual,
	input  wire logic [7:0]  app_resp_byte,
	// response byte request to the application logic
	output logic             resp_pull,
	// card operating state
	output tae_pkg::tae_card_t card_state
);

	tae_pkg::tae_seq_t seq;
	logic [7:0]  hdr_cla;
	logic [7:0]  hdr_ins;
	logic [7:0]  hdr_p3;
	logic [2:0]  hdr_idx;
	logic [8:0]  cnt;
	logic [15:0] avail;
	logic        warn_pend;
	logic [7:0]  warn_qual;
	logic [7:0]  sw1;
	logic [7:0]  sw2;
	logic        fix_pend;
	logic [7:0]  fix_ins;

	// length of the next portion: the smaller of the remaining data and 256
	function automatic logic [7:0] tae_chunk(input logic [15:0] left);
		tae_chunk = (left > `TAE_CHUNK_MAX) ? `TAE_LEN_ZERO : left[7:0];
	endfunction : tae_chunk

	// byte count a length byte stands for, 00 meaning 256
	function automatic logic [8:0] tae_count(input logic [7:0] len);
		tae_count = (len == `TAE_LEN_ZERO) ? `TAE_CNT_FULL : {1'b0, len};
	endfunction : tae_count

	////////////////////////////////////////////////////////////////////////////
	// card operating states
	always_ff @(posedge clk)
	begin
		if (!rst_n || !power_on)
			card_state <= tae_pkg::TAE_INACTIVE; // R8
		else
			case (card_state)
				tae_pkg::TAE_INACTIVE: card_state <= tae_pkg::TAE_APP_MGMT; // R9
				tae_pkg::TAE_APP_MGMT:
					if (pins_verified && session_ok)
						card_state <= tae_pkg::TAE_OPERATE; // R9 R10
				tae_pkg::TAE_OPERATE:
					if (!session_ok)
						card_state <= tae_pkg::TAE_APP_MGMT; // R9
				default: card_state <= tae_pkg::TAE_INACTIVE;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// exchange sequence
	always_ff @(posedge clk)
	begin
		tx_valid       <= 1'b0;
		cmd_start      <= 1'b0;
		cmd_byte_valid <= 1'b0;
		resp_pull      <= 1'b0;
		if (!rst_n || card_state == tae_pkg::TAE_INACTIVE)
		begin
			seq       <= tae_pkg::TAE_HDR; // R8
			hdr_cla   <= `TAE_BYTE_ZERO;
			hdr_ins   <= `TAE_BYTE_ZERO;
			hdr_p3    <= `TAE_BYTE_ZERO;
			hdr_idx   <= 3'h0;
			cnt       <= `TAE_CNT_ZERO;
			avail     <= `TAE_PARAM_ZERO;
			warn_pend <= 1'b0;
			warn_qual <= `TAE_BYTE_ZERO;
			sw1       <= `TAE_BYTE_ZERO;
			sw2       <= `TAE_BYTE_ZERO;
			fix_pend  <= 1'b0;
			fix_ins   <= `TAE_BYTE_ZERO;
			tx_data   <= `TAE_BYTE_ZERO;
			cmd_ins   <= `TAE_BYTE_ZERO;
			cmd_byte  <= `TAE_BYTE_ZERO;
		end
		else
			case (seq)
				// collect the five header bytes; R11 keeps them unoverlapped
				tae_pkg::TAE_HDR:
					if (rx_valid)
					begin
						if (hdr_idx == 3'h0)
							hdr_cla <= rx_data;
						if (hdr_idx == `TAE_IDX_INS)
							hdr_ins <= rx_data;
						if (hdr_idx == `TAE_IDX_P3)
						begin
							hdr_p3  <= rx_data;
							hdr_idx <= 3'h0;
							seq     <= tae_pkg::TAE_DECIDE;
						end
						else
							hdr_idx <= hdr_idx + 3'h1;
					end
				// pick the answer to the header
				tae_pkg::TAE_DECIDE:
					// fetch: a get response header, or the same header reissued after 6C
					if ((hdr_cla == `TAE_CLA_GETRESP && hdr_ins == `TAE_INS_GETRESP)
						|| (fix_pend && hdr_ins == fix_ins && hdr_p3 != `TAE_LEN_ZERO))
					begin
						if (avail == `TAE_PARAM_ZERO || tae_count(hdr_p3) > tae_count(tae_chunk(avail)))
						begin
							sw1 <= `TAE_SW1_WRONG_LE; // R2 R7
							sw2 <= tae_chunk(avail);
							seq <= tae_pkg::TAE_SW1;
						end
						else
						begin
							fix_pend <= 1'b0;
							tx_data  <= hdr_ins; // R2 R4
							tx_valid <= 1'b1;
							cnt      <= tae_count(hdr_p3);
							seq      <= tae_pkg::TAE_TX;
						end
					end
					else if (hdr_p3 == `TAE_LEN_ZERO && avail != `TAE_PARAM_ZERO)
					begin
						fix_pend <= 1'b1;
						fix_ins  <= hdr_ins;
						sw1      <= `TAE_SW1_WRONG_LE; // R2 R6
						sw2      <= tae_chunk(avail);
						seq      <= tae_pkg::TAE_SW1;
					end
					else
					begin
						fix_pend  <= 1'b0;
						cmd_ins   <= hdr_ins;
						cmd_start <= 1'b1;
						warn_pend <= 1'b0;
						avail     <= `TAE_PARAM_ZERO;
						cnt       <= {1'b0, hdr_p3};
						seq       <= tae_pkg::TAE_INS_IN;
					end
				// echo the instruction byte unless the header carries no data
				tae_pkg::TAE_INS_IN:
				begin
					if (cnt != `TAE_CNT_ZERO)
					begin
						tx_data  <= hdr_ins; // R3
						tx_valid <= 1'b1;
						seq      <= tae_pkg::TAE_RX;
					end
					else
						seq <= tae_pkg::TAE_RUN; // R1
				end
				// take the command data bytes
				tae_pkg::TAE_RX:
					if (rx_valid)
					begin
						cmd_byte       <= rx_data;
						cmd_byte_valid <= 1'b1;
						cnt            <= cnt - `TAE_CNT_ONE;
						if (cnt == `TAE_CNT_ONE)
							seq <= tae_pkg::TAE_RUN; // R3
					end
				// wait for the application, then report 90 00, 61, 62 or 6C
				tae_pkg::TAE_RUN:
					if (app_done)
					begin
						avail     <= app_resp_len;
						warn_pend <= app_warn;
						warn_qual <= app_warn_qual;
						if (app_warn)
						begin
							sw1 <= `TAE_SW1_WARN; // R7
							sw2 <= app_warn_qual;
						end
						// length 00 asked and data ready: report the true length
						else if (app_resp_len != `TAE_PARAM_ZERO && hdr_p3 == `TAE_LEN_ZERO)
						begin
							sw1      <= `TAE_SW1_WRONG_LE; // R2
							sw2      <= tae_chunk(app_resp_len);
							fix_pend <= 1'b1;
							fix_ins  <= hdr_ins;
						end
						else if (app_resp_len != `TAE_PARAM_ZERO)
						begin
							sw1 <= `TAE_SW1_MORE; // R4
							sw2 <= tae_chunk(app_resp_len);
						end
						else
						begin
							sw1 <= `TAE_SW1_OK; // R1 R3
							sw2 <= `TAE_SW2_OK;
						end
						seq <= tae_pkg::TAE_SW1;
					end
				tae_pkg::TAE_INS_TX:
					seq <= tae_pkg::TAE_TX;
				// send the requested portion of response data
				tae_pkg::TAE_TX:
					if (cnt == `TAE_CNT_ZERO)
					begin
						if (avail != `TAE_PARAM_ZERO)
						begin
							sw1 <= `TAE_SW1_MORE; // R5
							sw2 <= tae_chunk(avail);
						end
						else if (warn_pend)
						begin
							sw1 <= `TAE_SW1_WARN; // R7
							sw2 <= warn_qual;
						end
						else
						begin
							sw1 <= `TAE_SW1_OK; // R2 R4 R5
							sw2 <= `TAE_SW2_OK;
						end
						seq <= tae_pkg::TAE_SW1;
					end
					else
					begin
						tx_data   <= app_resp_byte;
						tx_valid  <= 1'b1;
						resp_pull <= 1'b1;
						cnt       <= cnt - `TAE_CNT_ONE;
						avail     <= avail - 16'h0001;
					end
				tae_pkg::TAE_SW1:
				begin
					tx_data  <= sw1;
					tx_valid <= 1'b1;
					seq      <= tae_pkg::TAE_SW2;
				end
				tae_pkg::TAE_SW2:
				begin
					tx_data  <= sw2;
					tx_valid <= 1'b1;
					seq      <= tae_pkg::TAE_HDR;
				end
				default: seq <= tae_pkg::TAE_HDR;
			endcase
	end

endmodule : tae_sequencer

/* pkg/tae_params.svh */
// constants for the t0 exchange sequencer
`ifndef TAE_PARAMS_SVH
`define TAE_PARAMS_SVH
`define TAE_HDR_LEN      3'h5
`define TAE_IDX_INS      3'h1
`define TAE_IDX_P3       3'h4
`define TAE_SW1_OK       8'h90
`define TAE_SW2_OK       8'h00
`define TAE_SW1_MORE     8'h61
`define TAE_SW1_WRONG_LE 8'h6C
`define TAE_SW1_WARN     8'h62
`define TAE_INS_GETRESP  8'hC0
`define TAE_CLA_GETRESP  8'h00
`define TAE_LEN_ZERO     8'h00
`define TAE_BYTE_ZERO    8'h00
`define TAE_CNT_ONE      9'h001
`define TAE_CNT_ZERO     9'h000
`define TAE_CNT_FULL     9'h100
`define TAE_CHUNK_MAX    16'h00FF
`define TAE_PARAM_ZERO   16'h0000
`endif

/* pkg/tae_pkg.sv */
// types for the t0 exchange sequencer
package tae_pkg;
	typedef enum logic [8:0] {
		TAE_HDR    = 9'h001,
		TAE_DECIDE = 9'h002,
		TAE_INS_IN = 9'h004,
		TAE_RX     = 9'h008,
		TAE_RUN    = 9'h010,
		TAE_INS_TX = 9'h020,
		TAE_TX     = 9'h040,
		TAE_SW1    = 9'h080,
		TAE_SW2    = 9'h100
	} tae_seq_t;
	typedef enum logic [2:0] {
		TAE_INACTIVE = 3'h1,
		TAE_APP_MGMT = 3'h2,
		TAE_OPERATE  = 3'h4
	} tae_card_t;
endpackage : tae_pkg

/* testbench/tae_sequencer_sva.sv */
// port assertions for the t0 sequencer
module tae_sequencer_sva (
	// clock and status
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             power_on,
	input wire logic             pins_verified,
	input wire logic             session_ok,
	// byte traffic
	input wire logic [7:0]       rx_data,
	input wire logic             rx_valid,
	input wire logic             tx_valid,
	input wire logic             cmd_start,
	input wire logic [7:0]       cmd_byte,
	input wire logic             cmd_byte_valid,
	input wire logic             resp_pull,
	input wire tae_pkg::tae_card_t card_state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// two unpowered cycles in a row
	sequence s_off; !power_on [*2]; endsequence
	property p_off_state; s_off |-> card_state == tae_pkg::TAE_INACTIVE; endproperty
	a_off_state: assert property (p_off_state) else $error("powered off but not inactive");
	property p_off_quiet; s_off |=> !tx_valid && !cmd_start && !resp_pull; endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("activity while unpowered");
	property p_start_on; cmd_start |-> $past(card_state) != tae_pkg::TAE_INACTIVE; endproperty
	a_start_on: assert property (p_start_on) else $error("command started while inactive");
	property p_wake; power_on && card_state == tae_pkg::TAE_INACTIVE |=> card_state == tae_pkg::TAE_APP_MGMT; endproperty
	a_wake: assert property (p_wake) else $error("no management state after power");
	property p_hold; power_on && card_state == tae_pkg::TAE_APP_MGMT && !pins_verified |=> card_state == tae_pkg::TAE_APP_MGMT; endproperty
	a_hold: assert property (p_hold) else $error("management left without pins");
	property p_operate; card_state == tae_pkg::TAE_OPERATE |-> $past(session_ok) && $past(power_on); endproperty
	a_operate: assert property (p_operate) else $error("operation without session");
	property p_cmd_data; cmd_byte_valid |-> $past(rx_valid) && cmd_byte == $past(rx_data); endproperty
	a_cmd_data: assert property (p_cmd_data) else $error("command byte not the received one");
	property p_pull; resp_pull |-> tx_valid || $past(tx_valid); endproperty
	a_pull: assert property (p_pull) else $error("response pulled without a sent byte");
endmodule : tae_sequencer_sva

bind tae_sequencer tae_sequencer_sva chk_u (.clk, .rst_n, .power_on, .pins_verified, .session_ok, .rx_data,
	.rx_valid, .tx_valid, .cmd_start, .cmd_byte, .cmd_byte_valid, .resp_pull, .card_state);

/* testbench/tae_term_model.sv */
// terminal model: sends bytes and collects replies
module tae_term_model (
	// clock
	input  wire logic       clk,
	// card to terminal
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	// terminal to card
	output logic      [7:0] rx_data,
	output logic            rx_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	initial rx_data = 8'h00;
	initial rx_valid = 1'b0;
	// gather every byte the card sends
	always @(posedge clk) if (tx_valid) got.push_back(tx_data);
	// one byte after an idle gap, line inverted once released
	task send(input logic [7:0] b, input int gap);
		repeat (gap + 1) @(negedge clk);
		rx_data = b;
		rx_valid = 1'b1;
		@(negedge clk);
		rx_data = ~b;
		rx_valid = 1'b0;
	endtask : send
endmodule : tae_term_model

/* testbench/tae_sequencer_tb.sv */
// self-checking bench for the t0 sequencer
module tae_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, power_on = 0, pins_verified = 0, session_ok = 0;
	logic        app_done = 0, app_warn = 0, tx_valid, rx_valid, cmd_start, cmd_byte_valid, resp_pull;
	logic [7:0]  rx_data, tx_data, cmd_ins, cmd_byte, app_resp_byte, app_warn_qual = 0, idx = 0, ins, len, e, db;
	logic [15:0] app_resp_len = 0;
	logic [31:0] seed = 32'd79913;
	logic [7:0]  exp[$];
	int          n_mismatch = 0, tests_run = 0;
	tae_pkg::tae_card_t card_state;
	always #20 clk = ~clk;
	tae_sequencer dut_u (.clk, .rst_n, .power_on, .pins_verified, .session_ok, .rx_data, .rx_valid, .tx_data,
		.tx_valid, .cmd_ins, .cmd_start, .cmd_byte, .cmd_byte_valid, .app_done, .app_resp_len, .app_warn,
		.app_warn_qual, .app_resp_byte, .resp_pull, .card_state);
	tae_term_model term_u (.clk, .tx_data, .tx_valid, .rx_data, .rx_valid);
	// application side: response bytes advance on each pull
	always @(posedge clk) idx <= app_done ? 8'h00 : idx + 8'(resp_pull);
	// a pull already shows the next byte, since the card sends one byte per cycle
	assign app_resp_byte = (idx + 8'(resp_pull)) ^ 8'h5A;
	////////////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// expected data bytes continue from the running index
	function void exp_data(input logic [7:0] n);
		repeat (n) exp.push_back(e++ ^ 8'h5A);
	endfunction : exp_data
	task check(input string what, input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin n_mismatch++; $display("ERROR %s expected %h seen %h", what, want, seen); end
	endtask : check
	task give_verdict();
		if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task wait_got(input int n);
		repeat (900) if (term_u.got.size() < n) @(negedge clk);
	endtask : wait_got
	// header, optional data after the echo, optional app answer, then compare all replies
	task xchg(input logic [7:0] cla, input logic [7:0] code, input logic [7:0] p3, input int nd, input bit run);
		term_u.got.delete();
		for (int i = 0; i < 5; i++) term_u.send(8'({cla, code, 16'h0000, p3} >> (8 * (4 - i))), rnd() % 3);
		wait_got(nd > 0);
		repeat (nd)
		begin
			db = 8'(rnd());
			term_u.send(db, rnd() % 2);
		end
		if (run) begin repeat (4) @(negedge clk); app_done = 1; @(negedge clk); app_done = 0; end
		wait_got(exp.size());
		repeat (3) @(negedge clk);
		check("reply count", 16'(term_u.got.size()), 16'(exp.size()));
		foreach (exp[i]) check("reply byte", term_u.got[i], exp[i]);
		if (run) check("command code", cmd_ins, code);
		if (nd > 0) check("last command byte", cmd_byte, db);
	endtask : xchg
	////////////////////////////////////////////////////////////////////////////
	initial begin repeat (20000) @(negedge clk); n_mismatch++; give_verdict(); end
	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		check("state", card_state, tae_pkg::TAE_INACTIVE);
		power_on = 1;
		repeat (2) @(negedge clk);
		check("state", card_state, tae_pkg::TAE_APP_MGMT);
		repeat (3) begin
			ins = rnd() & 8'h3E;
			len = rnd() % 8 + 1;
			app_warn = 0;
			app_resp_len = 0;
			exp = '{8'h90, 8'h00}; xchg(8'h80, ins, 8'h00, 0, 1);
			exp = '{ins, 8'h90, 8'h00}; xchg(8'h80, ins, len, len, 1);
			app_resp_len = len;
			e = 0; exp = '{8'h6C, len}; xchg(8'h80, ins, 8'h00, 0, 1);
			exp = '{ins}; exp_data(len); exp.push_back(8'h90); exp.push_back(8'h00); xchg(8'h80, ins, len, 0, 0);
			app_resp_len = 2 * len;
			e = 0; exp = '{ins, 8'h61, 2 * len}; xchg(8'h80, ins, len, len, 1);
			exp = '{8'hC0}; exp_data(len); exp.push_back(8'h61); exp.push_back(len); xchg(0, 8'hC0, len, 0, 0);
			exp = '{8'hC0}; exp_data(len); exp.push_back(8'h90); exp.push_back(8'h00); xchg(0, 8'hC0, len, 0, 0);
			app_resp_len = len;
			app_warn = 1;
			app_warn_qual = 8'(rnd());
			e = 0; exp = '{ins, 8'h62, app_warn_qual}; xchg(8'h80, ins, len, len, 1);
			exp = '{8'h6C, len}; xchg(0, 8'hC0, 8'h00, 0, 0);
			exp = '{8'hC0}; exp_data(len); exp.push_back(8'h62); exp.push_back(app_warn_qual); xchg(0, 8'hC0, len, 0, 0);
		end
		pins_verified = 1;
		session_ok = 1;
		repeat (3) @(negedge clk);
		check("state", card_state, tae_pkg::TAE_OPERATE);
		session_ok = 0;
		repeat (3) @(negedge clk);
		check("state", card_state, tae_pkg::TAE_APP_MGMT);
		power_on = 0;
		repeat (3) @(negedge clk);
		check("state", card_state, tae_pkg::TAE_INACTIVE);
		give_verdict();
	end
endmodule : tae_sequencer_tb
